// >>> rtl/adsq_consts.vh
// Constants for the 8-bit successive-approximation converter sequencer.
`ifndef ADSQ_CONSTS_VH
`define ADSQ_CONSTS_VH

// Register offsets.
`define ADSQ_OFS_RESULT    8'h0a
`define ADSQ_OFS_CTRL      8'h0b
`define ADSQ_OFS_IRQ_STAT  8'h0c
`define ADSQ_OFS_IRQ_EN    8'h0d
`define ADSQ_OFS_IRQ_CLR   8'h0e

// Control register field positions.
`define ADSQ_BIT_DONE      7
`define ADSQ_BIT_PWR       5
`define ADSQ_SEL_HI        1
`define ADSQ_SEL_LO        0

// Reset values.
`define ADSQ_RST_RESULT    8'h00
`define ADSQ_RST_CTRL      8'h00

// Timing: converter clock is the system clock divided by four.
`define ADSQ_CLK_DIV       4
`define ADSQ_CONV_CLKS     16
`define ADSQ_CONV_CYC      (`ADSQ_CONV_CLKS * `ADSQ_CLK_DIV)
`define ADSQ_CAL_CLKS      16
`define ADSQ_DIV_LAST      2'h3

// Interrupt status bit positions.
`define ADSQ_IRQ_DONE      0
`define ADSQ_IRQ_CAL       1

`endif

// >>> rtl/adsq_top.v
// Sequencer for a four-input, 8-bit successive-approximation converter.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`include "adsq_consts.vh"

module adsq_top
(
    // Clock, reset and enable.
    input  wire       clk,
    input  wire       reset_n,
    input  wire       clk_en,
    // Register port.
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Comparator answer from the analog front end and its input select.
    input  wire       cmp_above,
    input  wire       cpu_wait,
    input  wire [3:0] analog_pin_level,
    output reg  [1:0] mux_select,
    output reg  [7:0] dac_trial,
    output reg        sample_hold,
    output reg        analog_power,
    output reg  [3:0] port_level,
    // Interrupt.
    output reg        irq
);

    // How the sequencer spends its time.
    //
    // The converter is paced by an enable that fires on every fourth
    // system clock. Nothing runs on a second clock, so every flop in
    // this block shares one domain and no crossing logic is needed.
    //
    // After power is switched on, and after every control write that
    // leaves power on, the sequencer spends sixteen converter clocks
    // in calibration. Only then does it begin the first conversion.
    // Software must still allow the much longer analogue settling time
    // before it trusts a result; this block does not count that time.
    //
    // One conversion is sixteen converter clocks. The first eight are
    // the sample phase, which holds the trial at mid scale. The
    // last eight each decide one result bit, starting at the MSB. The
    // tick counter runs 0..7 in the sample phase and 8..15 during the
    // decisions, so a single counter covers the whole conversion.
    //
    // When the last bit is decided the result is stored, the done flag
    // is set and the next sample phase starts at once. The sequencer
    // keeps converting the selected input until power is removed.
    //
    // A control write always aborts the conversion in flight. The
    // done flag is cleared even if a conversion would have finished in
    // that very cycle: software asked for a restart and a result from
    // the old settings would be misleading.
    //
    // A result read clears the done flag, but a conversion finishing
    // in the same cycle wins. Otherwise the fresh result would sit in
    // the register with no flag to announce it.
    //
    // Hazards and limitations.
    // - The analogue front end is outside this block. cmp_above must
    //   be settled by the converter tick that follows a change of
    //   dac_trial; with four system clocks per tick there is margin.
    // - The comparator is sampled only on converter ticks, so glitches
    //   between ticks are harmless.
    // - cpu_wait is accepted but has no effect: the converter carries
    //   on while the processor waits.
    // - Pin levels are passed back one cycle late for port reads.
    // - The interrupt output is an addition for polled-free systems;
    //   the done flag itself never raises it unless enabled.
    //
    // Register map, by offset.
    // - 0a: result, read only.
    // - 0b: control and status.
    // - 0c: interrupt status, read only.
    // - 0d: interrupt enable.
    // - 0e: interrupt clear, write one to clear.

    // One-hot sequencer states.
    localparam [3:0] ST_OFF  = 4'h1;
    localparam [3:0] ST_CAL  = 4'h2;
    localparam [3:0] ST_SAMP = 4'h4;
    localparam [3:0] ST_CONV = 4'h8;

    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [1:0] div_ff;
    reg [4:0] tick_ff;
    reg [4:0] nxt_tick;
    reg [7:0] sar_ff;
    reg [7:0] nxt_sar;
    reg [7:0] trial_ff;
    reg [7:0] nxt_trial;
    reg [7:0] result_ff;
    reg       done_ff;
    reg       pwr_ff;
    reg [1:0] sel_ff;
    reg [1:0] irq_stat_ff;
    reg [1:0] irq_en_ff;
    reg       conv_fin;
    reg       cal_fin;

    wire      wr_ctrl;
    wire      rd_result;
    wire      cclk_tick;

    // Address match used by both read and write decode.
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    assign wr_ctrl   = reg_wr & hit(reg_addr, `ADSQ_OFS_CTRL);
    assign rd_result = reg_rd & hit(reg_addr, `ADSQ_OFS_RESULT);
    // The converter clock is an enable, not a derived clock, so there is
    // no second domain to cross; cpu_wait is deliberately not used.
    assign cclk_tick = (div_ff == `ADSQ_DIV_LAST);

    // Divide the system clock by four to pace the converter.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            div_ff <= 2'h0;
        else if (clk_en)
            div_ff <= div_ff + 2'h1;
    end

    // Sequencer next state: calibrate, sample, then eight SAR decisions.
    always @*
    begin
        nxt_state = state_ff;
        nxt_tick  = tick_ff;
        nxt_sar   = sar_ff;
        nxt_trial = trial_ff;
        conv_fin  = 1'b0;
        cal_fin   = 1'b0;
        case (state_ff)
            ST_OFF:
            begin
                nxt_tick = 5'h00;
                if (pwr_ff)
                    nxt_state = ST_CAL;
            end
            ST_CAL:
            begin
                if (cclk_tick)
                begin
                    nxt_tick = tick_ff + 5'h01;
                    if (tick_ff == `ADSQ_CAL_CLKS - 1)
                    begin
                        cal_fin   = 1'b1;
                        nxt_tick  = 5'h00;
                        nxt_state = ST_SAMP;
                    end
                end
            end
            ST_SAMP:
            begin
                // Eight clocks of sampling, trial held at mid scale, then
                // eight bit decisions: sixteen converter clocks in all.
                nxt_sar   = 8'h00;
                nxt_trial = 8'h80;
                if (cclk_tick)
                begin
                    nxt_tick = tick_ff + 5'h01;
                    if (tick_ff == 5'h07)
                        nxt_state = ST_CONV;
                end
            end
            ST_CONV:
            begin
                if (cclk_tick)
                begin
                    nxt_tick  = tick_ff + 5'h01;
                    nxt_sar   = cmp_above ? (sar_ff | trial_ff) : sar_ff;
                    nxt_trial = {1'b0, trial_ff[7:1]};
                    if (tick_ff == `ADSQ_CONV_CLKS - 1)
                    begin
                        conv_fin  = 1'b1;
                        nxt_tick  = 5'h00;
                        nxt_state = ST_SAMP;
                    end
                end
            end
            default:
            begin
                nxt_state = ST_OFF;
            end
        endcase
        if (!pwr_ff)
            nxt_state = ST_OFF;
    end

    // Sequencer registers; a control write restarts from calibration, or goes to ST_OFF when it clears power.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff <= ST_OFF;
            tick_ff  <= 5'h00;
            sar_ff   <= 8'h00;
            trial_ff <= 8'h80;
        end
        else if (clk_en)
        begin
            sar_ff   <= nxt_sar;
            trial_ff <= nxt_trial;
            if (wr_ctrl)
            begin
                state_ff <= reg_wdata[`ADSQ_BIT_PWR] ? ST_CAL : ST_OFF;
                tick_ff  <= 5'h00;
            end
            else
            begin
                state_ff <= nxt_state;
                tick_ff  <= nxt_tick;
            end
        end
    end

    // Control, result and done flag; a finishing conversion beats a
    // result read in the same cycle so no result is silently lost.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pwr_ff    <= 1'b0;
            sel_ff    <= 2'h0;
            result_ff <= `ADSQ_RST_RESULT;
            done_ff   <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_ctrl)
            begin
                pwr_ff  <= reg_wdata[`ADSQ_BIT_PWR];
                sel_ff  <= reg_wdata[`ADSQ_SEL_HI:`ADSQ_SEL_LO];
                done_ff <= 1'b0;
            end
            else if (conv_fin)
            begin
                result_ff <= nxt_sar;
                done_ff   <= 1'b1;
            end
            else if (rd_result)
                done_ff <= 1'b0;
        end
    end

    // Sticky interrupt status, enable and write-one-to-clear.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_stat_ff <= 2'h0;
            irq_en_ff   <= 2'h0;
        end
        else if (clk_en)
        begin
            if (reg_wr && hit(reg_addr, `ADSQ_OFS_IRQ_EN))
                irq_en_ff <= reg_wdata[1:0];
            irq_stat_ff <= (irq_stat_ff &
                ~((reg_wr && hit(reg_addr, `ADSQ_OFS_IRQ_CLR)) ?
                  reg_wdata[1:0] : 2'h0)) |
                {cal_fin, conv_fin & ~wr_ctrl};
        end
    end

    // Registered read data; unmapped addresses read as zero.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else if (clk_en)
        begin
            reg_rdata <= 8'h00;
            if (reg_rd)
            begin
                case (reg_addr)
                    `ADSQ_OFS_RESULT:
                        reg_rdata <= result_ff;
                    `ADSQ_OFS_CTRL:
                        reg_rdata <= {done_ff, 1'b0, pwr_ff, 3'h0, sel_ff};
                    `ADSQ_OFS_IRQ_STAT:
                        reg_rdata <= {6'h00, irq_stat_ff};
                    `ADSQ_OFS_IRQ_EN:
                        reg_rdata <= {6'h00, irq_en_ff};
                    default:
                        reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Registered outputs to the analog front end and the port readback.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mux_select   <= 2'h0;
            dac_trial    <= 8'h00;
            sample_hold  <= 1'b0;
            analog_power <= 1'b0;
            port_level   <= 4'h0;
            irq          <= 1'b0;
        end
        else if (clk_en)
        begin
            mux_select   <= sel_ff;
            dac_trial    <= nxt_sar | nxt_trial;
            sample_hold  <= (nxt_state == ST_SAMP);
            analog_power <= pwr_ff;
            port_level   <= analog_pin_level;
            irq          <= |(irq_stat_ff & irq_en_ff);
        end
    end

endmodule

// >>> dv/adsq_chk_asserts.sv
// Checker for the converter sequencer register port and timing.
`timescale 1ns/100ps
`include "adsq_consts.vh"

module adsq_chk
(
    // Clock and reset.
    input wire       clk,
    input wire       reset_n,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // Converter side.
    input wire [3:0] analog_pin_level,
    input wire [3:0] port_level,
    input wire       sample_hold,
    input wire [7:0] dac_trial,
    input wire       analog_power
);
    reg       live_ff;
    reg       ok_ff;
    reg       sh_ff;
    reg [7:0] gap_ff;
    wire      w_ctrl = reg_wr && reg_addr == `ADSQ_OFS_CTRL;
    wire      r_ctrl = reg_rd && reg_addr == `ADSQ_OFS_CTRL;
    wire      rise   = sample_hold && !sh_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Gap between sample starts; any write voids it, as a write may restart.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            live_ff <= 1'b0;
            ok_ff   <= 1'b0;
            sh_ff   <= 1'b0;
            gap_ff  <= 8'h00;
        end
        else
        begin
            live_ff <= 1'b1;
            sh_ff   <= sample_hold;
            gap_ff  <= rise ? 8'h00 : gap_ff + 8'h01;
            ok_ff   <= (reg_wr || !analog_power) ? 1'b0 : (rise | ok_ff);
        end
    end

    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    ctrl_rsvd_a: assert property (r_ctrl |=> reg_rdata[4:2] == 3'h0)
        else $error("reserved control bits set");
    unmapped_rd_a: assert property (reg_rd && reg_addr > 8'h0e |=>
        reg_rdata == 8'h00) else $error("unmapped read not zero");
    abort_clr_a: assert property (w_ctrl ##1 r_ctrl |=> !reg_rdata[7])
        else $error("done set after control write");
    pwr_on_a: assert property (w_ctrl && reg_wdata[5] ##1 !w_ctrl[*2]
        |-> analog_power) else $error("power did not turn on");
    pwr_off_a: assert property (w_ctrl && !reg_wdata[5] ##1 !w_ctrl[*2]
        |-> !analog_power) else $error("power did not turn off");
    port_copy_a: assert property (live_ff |->
        port_level == $past(analog_pin_level)) else $error("pin copy");
    conv_len_a: assert property (rise && ok_ff |-> gap_ff == 8'd63)
        else $error("conversion length wrong");
    trial_msb_a: assert property (sample_hold && $past(sample_hold) &&
        !$past(reg_wr) |-> dac_trial == 8'h80)
        else $error("sample trial not mid scale");
endmodule

bind adsq_top adsq_chk u_chk (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .analog_pin_level(analog_pin_level), .port_level(port_level),
    .sample_hold(sample_hold), .dac_trial(dac_trial),
    .analog_power(analog_power));

// >>> dv/adsq_tb.sv
// Self-checking bench for the converter sequencer.
`timescale 1ns/100ps
`include "adsq_consts.vh"

module tb;
    reg        clk       = 1'b0;
    reg        reset_n   = 1'b0;
    reg  [7:0] reg_addr  = 8'h00;
    reg  [7:0] reg_wdata = 8'h00;
    reg        reg_wr    = 1'b0;
    reg        reg_rd    = 1'b0;
    reg        cmp_above = 1'b0;
    reg        cpu_wait  = 1'b0;
    reg  [3:0] pins      = 4'h0;
    reg        pend      = 1'b0;
    reg [15:0] e;
    reg [15:0] exp_q[$];
    reg        got;
    wire [7:0] reg_rdata;
    wire [1:0] mux_select;
    wire       analog_power;
    wire       irq;
    integer    fail_count  = 0;
    integer    check_count = 0;
    integer    i;
    integer    s;

    adsq_top dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_above(cmp_above),
        .cpu_wait(cpu_wait), .analog_pin_level(pins),
        .mux_select(mux_select), .dac_trial(), .sample_hold(),
        .analog_power(analog_power), .port_level(), .irq(irq));

    always #5 clk = ~clk;

    // Random pin levels and wait requests; neither may disturb conversion.
    always @(posedge clk)
    begin
        pins     <= 4'($urandom);
        cpu_wait <= 1'($urandom);
    end

    task chk(input [7:0] v, input [7:0] x, input [7:0] m);
    begin
        check_count = check_count + 1;
        if ((v & m) !== (x & m))
        begin
            fail_count = fail_count + 1;
            $display("ERROR %0t: got %h want %h", $time, v, x);
        end
    end
    endtask

    // One bus cycle; a read notes {mask, value} for the monitor.
    task op(input w, input r, input [7:0] a, input [7:0] d,
            input [15:0] x);
    begin
        reg_wr    <= w;
        reg_rd    <= r;
        reg_addr  <= a;
        reg_wdata <= d;
        if (r)
            exp_q.push_back(x);
        @(posedge clk);
    end
    endtask

    task idle(input integer n);
        repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00, 16'h0000);
    endtask

    // Read data stand only in the cycle after the strobe.
    always @(posedge clk)
    begin
        if (pend)
        begin
            e = exp_q.pop_front();
            chk(reg_rdata, e[7:0], e[15:8]);
        end
        pend <= reg_rd;
    end

    // Polls the control register until the done flag shows, bounded.
    task poll;
    begin
        got = 1'b0;
        for (i = 0; i < 200 && !got; i = i + 1)
        begin
            op(1'b0, 1'b1, `ADSQ_OFS_CTRL, 8'h00, 16'h0000);
            #1 got = (reg_rdata[7] === 1'b1);
        end
        chk({7'h0, got}, 8'h01, 8'h01);
    end
    endtask

    task irqc(input x);
    begin
        idle(3);
        #1 chk({7'h0, irq}, {7'h0, x}, 8'h01);
    end
    endtask

    task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask

    initial
    begin
        #60000;
        fail_count = fail_count + 1;
        tally_and_finish;
    end

    initial
    begin
        s = $urandom(32'h5a7fa7ac);
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        op(1'b1, 1'b0, `ADSQ_OFS_RESULT, 8'h5a, 16'h0000);
        op(1'b1, 1'b0, 8'hf0, 8'hff, 16'h0000);
        op(1'b0, 1'b1, `ADSQ_OFS_RESULT, 8'h00, 16'hff00);
        op(1'b0, 1'b1, `ADSQ_OFS_CTRL, 8'h00, 16'hff00);
        op(1'b0, 1'b1, 8'hf0, 8'h00, 16'hff00);
        #1 chk({7'h0, analog_power}, 8'h00, 8'h01);
        // Each input in turn; a steady comparator gives all ones or zeros.
        for (s = 0; s < 4; s = s + 1)
        begin
            cmp_above <= s[0];
            op(1'b1, 1'b0, `ADSQ_OFS_CTRL, 8'h20 | s[7:0], 16'h0000);
            op(1'b0, 1'b1, `ADSQ_OFS_CTRL, 8'h00,
               {8'hff, 8'h20 | s[7:0]});
            idle(3);
            #1 chk({6'h0, mux_select}, s[7:0], 8'h03);
            poll;
            op(1'b0, 1'b1, `ADSQ_OFS_RESULT, 8'h00,
               {8'hff, {8{s[0]}}});
            op(1'b0, 1'b1, `ADSQ_OFS_CTRL, 8'h00, 16'h8000);
        end
        idle(150);
        // Interrupt raised, masked, re-enabled and cleared after a finish.
        op(1'b0, 1'b1, `ADSQ_OFS_RESULT, 8'h00, 16'h0000);
        poll;
        op(1'b1, 1'b0, `ADSQ_OFS_IRQ_EN, 8'h01, 16'h0000);
        irqc(1'b1);
        op(1'b1, 1'b0, `ADSQ_OFS_IRQ_EN, 8'h00, 16'h0000);
        irqc(1'b0);
        op(1'b1, 1'b0, `ADSQ_OFS_IRQ_EN, 8'h01, 16'h0000);
        irqc(1'b1);
        op(1'b1, 1'b0, `ADSQ_OFS_IRQ_CLR, 8'h01, 16'h0000);
        irqc(1'b0);
        op(1'b0, 1'b1, `ADSQ_OFS_IRQ_STAT, 8'h00, 16'h0100);
        op(1'b1, 1'b0, `ADSQ_OFS_CTRL, 8'h00, 16'h0000);
        idle(3);
        #1 chk({7'h0, analog_power}, 8'h00, 8'h01);
        tally_and_finish;
    end
endmodule
